// >>> rtl/mob_pkg.sv
/*
 constants for the memory ordering barrier: barrier type codes, field position, states.
 assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package mob_pkg;
    localparam int TYPE_LSB = 6;
    localparam int TYPE_MSB = 10;
    localparam logic [4:0] TYPE_FULL = 5'h00;
    localparam logic [4:0] TYPE_STORE_STORE = 5'h04;
    localparam logic [4:0] TYPE_FULL_ORDER = 5'h10;
    localparam logic [4:0] TYPE_ACQUIRE = 5'h11;
    localparam logic [4:0] TYPE_RELEASE = 5'h12;
    localparam logic [4:0] TYPE_LOAD_LOAD = 5'h13;
    localparam logic [4:0] TYPE_GLOBAL_INV = 5'h14;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_RESET = 6'h00;
    typedef enum logic [3:0] {
        MOB_IDLE = 4'b0001,
        MOB_ORDER = 4'b0010,
        MOB_COMPLETE = 4'b0100,
        MOB_RETIRE = 4'b1000
    } mob_state_e;
endpackage
`default_nettype wire

// >>> rtl/mob_decode.sv
/*
 decodes the barrier type field into older/younger load and store selections and a mode.
 assumes a valid instruction word from the issue stage, same clock.
*/
`default_nettype none
module mob_decode (
    // instruction and configuration
    input wire logic [31:0] instr,
    input wire logic global_invalidate_support_field,
    // decoded selection
    output logic older_ld,
    output logic older_st,
    output logic younger_ld,
    output logic younger_st,
    output logic completion,
    output logic wait_global_inv
);
    logic [4:0] stype;
    assign stype = instr[mob_pkg::TYPE_MSB:mob_pkg::TYPE_LSB];
    always_comb begin
        // everything not given its own behaviour falls back to the full completion barrier
        older_ld = 1'b1;
        older_st = 1'b1;
        younger_ld = 1'b1;
        younger_st = 1'b1;
        completion = 1'b1;
        wait_global_inv = 1'b0;
        case (stype)
            mob_pkg::TYPE_STORE_STORE: begin
                older_ld = 1'b0;
                younger_ld = 1'b0;
                completion = 1'b0;
            end
            mob_pkg::TYPE_FULL_ORDER: begin
                completion = 1'b0;
            end
            mob_pkg::TYPE_LOAD_LOAD: begin
                older_st = 1'b0;
                younger_st = 1'b0;
                completion = 1'b0;
            end
            mob_pkg::TYPE_ACQUIRE: begin
                older_st = 1'b0;
                completion = 1'b0;
            end
            mob_pkg::TYPE_RELEASE: begin
                younger_ld = 1'b0;
                completion = 1'b0;
            end
            mob_pkg::TYPE_GLOBAL_INV: begin
                // reserved without support, so it degrades to the full barrier
                if (global_invalidate_support_field) begin
                    completion = 1'b0;
                    wait_global_inv = 1'b1;
                end
            end
            default: begin
                completion = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> rtl/mob_counter.sv
/*
 counts accesses in flight: increments on a start pulse, decrements on a finish pulse.
 assumes the two pulses come from logic on the same clock and never underflow.
*/
`default_nettype none
module mob_counter (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // events
    input wire logic inc,
    input wire logic dec,
    // state
    output logic zero
);
    logic [mob_pkg::CNT_W-1:0] cnt_reg;
    logic [mob_pkg::CNT_W-1:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (inc && !dec) begin
            cnt_next = cnt_reg + 6'h01;
        end else if (dec && !inc) begin
            cnt_next = cnt_reg - 6'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= mob_pkg::CNT_RESET;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign zero = (cnt_reg == mob_pkg::CNT_RESET);
endmodule
`default_nettype wire

// >>> rtl/mob_barrier.sv
/*
 memory ordering barrier control: holds a barrier instruction and gates issue of younger
 loads and stores until older ones have reached the ordering point or completed.
 assumes the load/store path reports, per access, when it passes the ordering point,
 when a load writes its register and when a store is globally visible; all on clk.
*/
`default_nettype none
module mob_barrier (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic global_invalidate_support_field,
    // barrier instruction from issue
    input wire logic barrier_valid,
    input wire logic [31:0] barrier_instr,
    output logic barrier_ready,
    output logic barrier_retire,
    // younger access issue request
    input wire logic acc_valid,
    input wire logic acc_is_store,
    input wire logic acc_is_load,
    input wire logic acc_sync_type,
    output logic acc_grant,
    // load/store path progress of tracked accesses
    input wire logic ld_reach_order,
    input wire logic st_reach_order,
    input wire logic ld_reg_written,
    input wire logic st_global_visible,
    // global invalidate and icache sync tracking
    input wire logic ginv_issue,
    input wire logic ginv_done,
    input wire logic icache_sync_issue,
    input wire logic icache_sync_done,
    // status
    output logic barrier_busy
);
    logic older_ld;
    logic older_st;
    logic younger_ld;
    logic younger_st;
    logic completion;
    logic wait_global_inv;
    logic tracked_issue;
    logic ld_ord_zero;
    logic st_ord_zero;
    logic ld_cmp_zero;
    logic st_cmp_zero;
    logic ginv_zero;
    logic isync_zero;
    mob_pkg::mob_state_e state_reg;
    mob_pkg::mob_state_e state_next;
    logic sel_ld_reg;
    logic sel_ld_next;
    logic sel_st_reg;
    logic sel_st_next;
    logic yng_ld_reg;
    logic yng_ld_next;
    logic yng_st_reg;
    logic yng_st_next;
    logic ginv_wait_reg;
    logic ginv_wait_next;
    logic busy_reg;
    logic busy_next;
    logic order_met;
    logic complete_met;
    logic blocked;

    mob_decode u_decode (
        .instr(barrier_instr),
        .global_invalidate_support_field(global_invalidate_support_field),
        .older_ld(older_ld),
        .older_st(older_st),
        .younger_ld(younger_ld),
        .younger_st(younger_st),
        .completion(completion),
        .wait_global_inv(wait_global_inv)
    );

    // only synchronizable accesses are counted; others pass unless a barrier is taken in the same cycle
    assign tracked_issue = acc_grant && acc_sync_type;

    // the caller flags cache ops and fetch hints as loads or stores
    mob_counter u_ld_ord (
        .clk(clk),
        .rst(rst),
        .inc(tracked_issue && acc_is_load),
        .dec(ld_reach_order),
        .zero(ld_ord_zero)
    );
    mob_counter u_st_ord (
        .clk(clk),
        .rst(rst),
        .inc(tracked_issue && acc_is_store),
        .dec(st_reach_order),
        .zero(st_ord_zero)
    );
    mob_counter u_ld_cmp (
        .clk(clk),
        .rst(rst),
        .inc(tracked_issue && acc_is_load),
        .dec(ld_reg_written),
        .zero(ld_cmp_zero)
    );
    mob_counter u_st_cmp (
        .clk(clk),
        .rst(rst),
        .inc(tracked_issue && acc_is_store),
        .dec(st_global_visible),
        .zero(st_cmp_zero)
    );
    mob_counter u_ginv (
        .clk(clk),
        .rst(rst),
        .inc(ginv_issue),
        .dec(ginv_done),
        .zero(ginv_zero)
    );
    mob_counter u_isync (
        .clk(clk),
        .rst(rst),
        .inc(icache_sync_issue),
        .dec(icache_sync_done),
        .zero(isync_zero)
    );

    // passing the ordering point is enough for the lighter barrier
    assign order_met = (!sel_ld_reg || ld_ord_zero) && (!sel_st_reg || st_ord_zero);
    assign complete_met = (!sel_ld_reg || ld_cmp_zero) && (!sel_st_reg || st_cmp_zero)
        && (!ginv_wait_reg || (ginv_zero && isync_zero));

    always_comb begin
        state_next = state_reg;
        sel_ld_next = sel_ld_reg;
        sel_st_next = sel_st_reg;
        yng_ld_next = yng_ld_reg;
        yng_st_next = yng_st_reg;
        ginv_wait_next = ginv_wait_reg;
        busy_next = busy_reg;
        case (state_reg)
            mob_pkg::MOB_IDLE: begin
                if (barrier_valid) begin
                    sel_ld_next = older_ld;
                    sel_st_next = older_st;
                    yng_ld_next = younger_ld;
                    yng_st_next = younger_st;
                    ginv_wait_next = wait_global_inv;
                    busy_next = 1'b1;
                    if (completion || wait_global_inv) begin
                        state_next = mob_pkg::MOB_COMPLETE;
                    end else begin
                        state_next = mob_pkg::MOB_ORDER;
                    end
                end
            end
            mob_pkg::MOB_ORDER: begin
                if (order_met) begin
                    state_next = mob_pkg::MOB_RETIRE;
                end
            end
            mob_pkg::MOB_COMPLETE: begin
                // every barrier held here, completion or invalidate type, also needs the ordering point drained
                if (complete_met && order_met) begin
                    state_next = mob_pkg::MOB_RETIRE;
                end
            end
            mob_pkg::MOB_RETIRE: begin
                busy_next = 1'b0;
                state_next = mob_pkg::MOB_IDLE;
            end
            default: begin
                busy_next = 1'b0;
                state_next = mob_pkg::MOB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= mob_pkg::MOB_IDLE;
            sel_ld_reg <= 1'b0;
            sel_st_reg <= 1'b0;
            yng_ld_reg <= 1'b0;
            yng_st_reg <= 1'b0;
            ginv_wait_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sel_ld_reg <= sel_ld_next;
            sel_st_reg <= sel_st_next;
            yng_ld_reg <= yng_ld_next;
            yng_st_reg <= yng_st_next;
            ginv_wait_reg <= ginv_wait_next;
            busy_reg <= busy_next;
        end
    end

    // instruction fetch has no port here, so it is never held back
    assign blocked = busy_reg && acc_sync_type
        && ((acc_is_load && yng_ld_reg) || (acc_is_store && yng_st_reg));
    // a barrier arriving in the same cycle also holds younger accesses
    assign acc_grant = acc_valid && !blocked && !(barrier_valid && state_reg == mob_pkg::MOB_IDLE);
    assign barrier_ready = (state_reg == mob_pkg::MOB_IDLE);
    assign barrier_retire = (state_reg == mob_pkg::MOB_RETIRE);
    assign barrier_busy = busy_reg;
endmodule
`default_nettype wire

// >>> tb/mob_barrier_asserts.sv
/*
 port checker for the barrier control.
 assumes a bind onto mob_barrier, one clock, synchronous reset.
*/
`default_nettype none
module mob_barrier_chk (
    // clock, reset and barrier handshake
    input wire logic clk, rst, barrier_valid, barrier_ready, barrier_retire,
    input wire logic [31:0] barrier_instr,
    // younger access issue and status
    input wire logic acc_valid, acc_is_store, acc_is_load, acc_sync_type,
    input wire logic acc_grant, barrier_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] type_reg;
    logic take, yst, yld;
    assign take = barrier_valid && barrier_ready;
    // only 0x13 leaves younger stores free; 0x4 and 0x12 leave younger loads free
    assign yst = type_reg != 5'h13;
    assign yld = type_reg != 5'h04 && type_reg != 5'h12;
    always_ff @(posedge clk) begin
        if (take) begin
            type_reg <= barrier_instr[10:6];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ready_idle_a: assert property (barrier_ready == !barrier_busy)
        else $error("ready and busy disagree");
    take_busy_a: assert property (take |=> barrier_busy)
        else $error("busy missing after take");
    min_lat_a: assert property (take |=> !barrier_retire)
        else $error("retire too early");
    retire_once_a: assert property (barrier_retire |=> !barrier_retire && !barrier_busy)
        else $error("retire not a single pulse");
    offer_block_a: assert property (take |-> !acc_grant)
        else $error("grant in take cycle");
    nonsync_a: assert property (acc_valid && !acc_sync_type && !take |-> acc_grant)
        else $error("untracked access refused");
    st_block_a: assert property (barrier_busy && acc_valid && acc_sync_type
        && acc_is_store && yst |-> !acc_grant)
        else $error("younger store granted");
    ld_block_a: assert property (barrier_busy && acc_valid && acc_sync_type
        && acc_is_load && yld |-> !acc_grant)
        else $error("younger load granted");
    grant_src_a: assert property (acc_grant |-> acc_valid)
        else $error("grant without request");
    take_c: cover property (take);
    retire_c: cover property (barrier_retire);
    refuse_c: cover property (barrier_busy && acc_valid && !acc_grant);
endmodule
`default_nettype wire

// >>> tb/mob_lsu_model.sv
/*
 load/store path stand-in: tracked accesses pass the ordering point, then complete.
 assumes grants from mob_barrier; the holds come from the bench to slow it down.
*/
`default_nettype none
module mob_lsu_model (
    // clock and reset
    input wire logic clk, rst,
    // granted access and holds
    input wire logic acc_grant, acc_is_load, acc_is_store, acc_sync_type,
    input wire logic hold_order, hold_done,
    // progress pulses
    output logic ld_reach_order, st_reach_order, ld_reg_written, st_global_visible
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lo_reg, so_reg, lw_reg, sw_reg;
    logic tr;
    assign tr = acc_grant && acc_sync_type; // other access types untracked
    assign ld_reach_order = !hold_order && lo_reg != 6'h00;
    assign st_reach_order = !hold_order && so_reg != 6'h00;
    // completion only after the ordering point, one unit per pulse
    assign ld_reg_written = !hold_done && lw_reg != 6'h00;
    assign st_global_visible = !hold_done && sw_reg != 6'h00;
    always_ff @(posedge clk) begin
        if (rst) begin
            {lo_reg, so_reg, lw_reg, sw_reg} <= 24'h0;
        end else begin
            lo_reg <= lo_reg + 6'(tr && acc_is_load) - 6'(ld_reach_order);
            so_reg <= so_reg + 6'(tr && acc_is_store) - 6'(st_reach_order);
            lw_reg <= lw_reg + 6'(ld_reach_order) - 6'(ld_reg_written);
            sw_reg <= sw_reg + 6'(st_reach_order) - 6'(st_global_visible);
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_memory_ordering_barrier.sv
/*
 bench for mob_barrier: one task a scenario, path model on the far side.
 assumes a 20 MHz clock and synchronous active-high reset.
*/
`default_nettype none
module tb_memory_ordering_barrier;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, global_invalidate_support_field = 1'h0;
    logic barrier_valid = 1'h0, barrier_ready, barrier_retire, barrier_busy;
    logic [31:0] barrier_instr = 32'h0;
    logic acc_valid = 1'h0, acc_is_store = 1'h0, acc_is_load = 1'h0;
    logic acc_sync_type = 1'h0, acc_grant, hold_order = 1'h0, hold_done = 1'h0;
    logic ginv_issue = 1'h0, ginv_done = 1'h0;
    logic icache_sync_issue = 1'h0, icache_sync_done = 1'h0;
    logic ld_reach_order, st_reach_order, ld_reg_written, st_global_visible;
    int n_errors = 0, checks = 0, cyc = 0;
    mob_barrier dut (.clk, .rst, .global_invalidate_support_field, .barrier_valid,
        .barrier_instr, .barrier_ready, .barrier_retire, .acc_valid, .acc_is_store,
        .acc_is_load, .acc_sync_type, .acc_grant, .ld_reach_order, .st_reach_order,
        .ld_reg_written, .st_global_visible, .ginv_issue, .ginv_done,
        .icache_sync_issue, .icache_sync_done, .barrier_busy);
    mob_lsu_model lsu (.clk, .rst, .acc_grant, .acc_is_load, .acc_is_store,
        .acc_sync_type, .hold_order, .hold_done, .ld_reach_order, .st_reach_order,
        .ld_reg_written, .st_global_visible);
    always #25 clk = !clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic ld, input logic sync, input logic exp);
        acc_valid = 1'h1;
        acc_is_load = ld;
        acc_is_store = !ld;
        acc_sync_type = sync;
        #1;
        cmp("acc_grant", 32'(exp), 32'(acc_grant));
        // valid stays up so a following access never drops and raises it in one step
        tick();
    endtask
    task automatic offer(input logic [4:0] t);
        acc_valid = 1'h0;
        barrier_valid = 1'h1;
        barrier_instr = {21'h0, t, 6'h0};
        tick();
        barrier_valid = 1'h0;
    endtask
    // looks for the retire pulse over n cycles
    task automatic wait_ret(input int n, input logic exp);
        logic seen;
        seen = 1'h0;
        acc_valid = 1'h0;
        repeat (n) begin
            if (barrier_retire === 1'h1) seen = 1'h1;
            tick();
        end
        cmp("barrier_retire", 32'(exp), 32'(seen));
    endtask
    task automatic t_reset();
        cmp("barrier_ready", 32'h1, 32'(barrier_ready));
        cmp("barrier_busy", 32'h0, 32'(barrier_busy));
        $display("t_reset done");
    endtask
    task automatic t_order();
        hold_order = 1'h1;
        hold_done = 1'h1;
        acc(1'h1, 1'h1, 1'h1);
        offer(5'h10);
        acc(1'h1, 1'h1, 1'h0);
        acc(1'h0, 1'h0, 1'h1);
        wait_ret(6, 1'h0);
        hold_order = 1'h0;
        wait_ret(8, 1'h1);
        hold_done = 1'h0;
        tick(4);
        $display("t_order done");
    endtask
    task automatic t_full();
        logic [4:0] codes [4] = '{5'h00, 5'h07, 5'h15, 5'h14};
        foreach (codes[i]) begin
            hold_done = 1'h1;
            acc(1'h0, 1'h1, 1'h1);
            offer(codes[i]);
            acc(1'h1, 1'h1, 1'h0);
            wait_ret(8, 1'h0);
            hold_done = 1'h0;
            wait_ret(10, 1'h1);
        end
        $display("t_full done");
    endtask
    task automatic t_kinds();
        // type in the upper five bits, then younger load and store grant
        logic [6:0] tab [4] = '{7'h12, 7'h4d, 7'h44, 7'h4a};
        foreach (tab[i]) begin
            hold_order = 1'h1;
            acc(1'h1, 1'h1, 1'h1);
            acc(1'h0, 1'h1, 1'h1);
            offer(tab[i][6:2]);
            acc(1'h1, 1'h1, tab[i][1]);
            acc(1'h0, 1'h1, tab[i][0]);
            wait_ret(4, 1'h0);
            hold_order = 1'h0;
            wait_ret(10, 1'h1);
        end
        $display("t_kinds done");
    endtask
    task automatic t_ginv();
        global_invalidate_support_field = 1'h1;
        hold_order = 1'h1;
        ginv_issue = 1'h1;
        icache_sync_issue = 1'h1;
        acc(1'h1, 1'h1, 1'h1);
        ginv_issue = 1'h0;
        icache_sync_issue = 1'h0;
        offer(5'h14);
        acc(1'h1, 1'h1, 1'h0);
        wait_ret(6, 1'h0);
        ginv_done = 1'h1;
        tick();
        ginv_done = 1'h0;
        wait_ret(6, 1'h0);
        icache_sync_done = 1'h1;
        tick();
        icache_sync_done = 1'h0;
        // the older load is still short of the ordering point
        wait_ret(6, 1'h0);
        hold_order = 1'h0;
        wait_ret(8, 1'h1);
        global_invalidate_support_field = 1'h0;
        $display("t_ginv done");
    endtask
    task automatic print_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        tick(16);
        rst = 1'h0;
        t_reset();
        t_order();
        t_full();
        t_kinds();
        t_ginv();
        print_verdict();
    end
endmodule
bind mob_barrier mob_barrier_chk chk_i (.clk, .rst, .barrier_valid, .barrier_ready,
    .barrier_retire, .barrier_instr, .acc_valid, .acc_is_store, .acc_is_load,
    .acc_sync_type, .acc_grant, .barrier_busy);
`default_nettype wire
